// *** rtl/cal_pkg.sv ***
// constants for the calendar and alarm register block
package cal_pkg;
   // register addresses on the device's internal register port
   localparam logic [7:0] ADDR_WEEKDAY  = 8'h08;
   localparam logic [7:0] ADDR_MONTH    = 8'h09;
   localparam logic [7:0] ADDR_YEAR     = 8'h0a;
   localparam logic [7:0] ADDR_SEC_ALM  = 8'h0b;
   localparam logic [7:0] ADDR_MIN_ALM  = 8'h0c;
   // reset values
   localparam logic [7:0] RST_WEEKDAY   = 8'h06;
   localparam logic [7:0] RST_MONTH     = 8'h01;
   localparam logic [7:0] RST_YEAR      = 8'h00;
   localparam logic [7:0] RST_ALARM     = 8'h80;
   // field layout
   localparam int         WEEKDAY_W     = 3;
   localparam int         MONTH_W       = 5;
   localparam int         ALM_VAL_W     = 7;
   localparam int         ALM_EN_BIT    = 7;
   localparam logic [2:0] WEEKDAY_MAX   = 3'h6;
   localparam logic [4:0] MONTH_FEB     = 5'h02;
   localparam logic [4:0] MONTH_DEC     = 5'h12;
   localparam logic [7:0] YEAR_MAX      = 8'h99;
endpackage

// *** rtl/cal_bcd_inc.sv ***
// two-digit bcd incrementer with wrap
`timescale 1ns/10ps
module cal_bcd_inc #(
   parameter int W = 8
) (
   // operand
   input  wire logic [W-1:0] i_val,
   input  wire logic [W-1:0] i_max,
   input  wire logic [W-1:0] i_min,
   // result
   output logic      [W-1:0] o_val,
   output logic              o_wrap
);
   logic [7:0] v;
   logic [7:0] n;
   always_comb begin
      v = 8'(i_val);
      if (v[3:0] == 4'h9) begin
         n = {4'(v[7:4] + 4'h1), 4'h0};
      end else begin
         n = {v[7:4], 4'(v[3:0] + 4'h1)};
      end
      o_wrap = (i_val == i_max);
      o_val  = o_wrap ? i_min : n[W-1:0];
   end
endmodule // cal_bcd_inc

// *** rtl/cal_month_len.sv ***
// last day of a month in bcd, leap years 2000 to 2099
`timescale 1ns/10ps
module cal_month_len (
   // calendar state
   input  wire logic [4:0] i_month,
   input  wire logic [7:0] i_year,
   // result
   output logic      [5:0] o_last_day
);
   logic leap;
   always_comb begin
      // bcd value divisible by four: tens even needs units 0/4/8, odd needs 2/6
      leap = i_year[4] ? (i_year[1:0] == 2'h2) : (i_year[1:0] == 2'h0);
      unique case (i_month)
         5'h02:                      o_last_day = leap ? 6'h29 : 6'h28;
         5'h04, 5'h06, 5'h09, 5'h11: o_last_day = 6'h30;
         default:                    o_last_day = 6'h31;
      endcase
   end
endmodule // cal_month_len

// *** rtl/cal_regs.sv ***
// weekday, month, year counters and seconds/minutes alarm registers
// What this block does
// - weekday in bits 2:0, counts 0 to 6, upper bits read zero, resets to 6
// - month bcd in bits 4:0, 01 to 12, upper bits zero, resets to 01
// - year bcd in all eight bits, 00 to 99, resets to 00
// - leap february for every year divisible by four, 2000 to 2099
// - seconds alarm bit 7 is active-low enable, resets to one
// - seconds alarm match value bcd in bits 6:0, resets to zero
// - minutes alarm bit 7 is active-low enable, resets to one
// - minutes alarm match value bcd in bits 6:0, resets to zero
`timescale 1ns/10ps
module cal_regs (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_ce,
   // internal register port
   input  wire logic [7:0] i_addr,
   input  wire logic       i_wr,
   input  wire logic [7:0] i_wdata,
   output logic      [7:0] o_rdata,
   output logic            o_hit,
   // from the date counter
   input  wire logic       i_day_roll,
   input  wire logic [5:0] i_date,
   // to the date counter and alarm compare
   output logic      [5:0] o_last_day,
   output logic      [2:0] o_weekday,
   output logic      [4:0] o_month,
   output logic      [7:0] o_year,
   output logic            o_sec_alm_en_n,
   output logic      [6:0] o_sec_alm_val,
   output logic            o_min_alm_en_n,
   output logic      [6:0] o_min_alm_val
);
   logic [2:0] weekday_r;
   logic [4:0] month_r;
   logic [7:0] year_r;
   logic [7:0] sec_alm_r;
   logic [7:0] min_alm_r;
   logic [4:0] month_nxt;
   logic [7:0] year_nxt;
   logic       month_wrap;
   logic       month_end;
   logic       wr_ok;

   assign wr_ok     = i_ce && i_wr;
   // software data is assumed valid bcd; no range guarding is spent here
   assign month_end = i_day_roll && (i_date == o_last_day);

   cal_month_len u_len (
      .i_month    (month_r),
      .i_year     (year_r),
      .o_last_day (o_last_day)
   );

   cal_bcd_inc #(.W(5)) u_month_inc (
      .i_val  (month_r),
      .i_max  (cal_pkg::MONTH_DEC),
      .i_min  (cal_pkg::RST_MONTH[4:0]),
      .o_val  (month_nxt),
      .o_wrap (month_wrap)
   );

   cal_bcd_inc #(.W(8)) u_year_inc (
      .i_val  (year_r),
      .i_max  (cal_pkg::YEAR_MAX),
      .i_min  (cal_pkg::RST_YEAR),
      .o_val  (year_nxt),
      .o_wrap ()
   );

   // weekday: software write wins over the rollover step in the same cycle
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         weekday_r <= cal_pkg::RST_WEEKDAY[2:0];
      end else if (i_ce) begin
         if (wr_ok && i_addr == cal_pkg::ADDR_WEEKDAY) begin
            weekday_r <= i_wdata[2:0];
         end else if (i_day_roll) begin
            weekday_r <= (weekday_r == cal_pkg::WEEKDAY_MAX) ? 3'h0
                         : 3'(weekday_r + 3'h1);
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         month_r <= cal_pkg::RST_MONTH[4:0];
      end else if (i_ce) begin
         if (wr_ok && i_addr == cal_pkg::ADDR_MONTH) begin
            month_r <= i_wdata[4:0];
         end else if (month_end) begin
            month_r <= month_nxt;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         year_r <= cal_pkg::RST_YEAR;
      end else if (i_ce) begin
         if (wr_ok && i_addr == cal_pkg::ADDR_YEAR) begin
            year_r <= i_wdata;
         end else if (month_end && month_wrap) begin
            year_r <= year_nxt;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sec_alm_r <= cal_pkg::RST_ALARM;
         min_alm_r <= cal_pkg::RST_ALARM;
      end else if (wr_ok) begin
         if (i_addr == cal_pkg::ADDR_SEC_ALM) begin
            sec_alm_r <= i_wdata;
         end
         if (i_addr == cal_pkg::ADDR_MIN_ALM) begin
            min_alm_r <= i_wdata;
         end
      end
   end

   // read mux; unused upper bits read zero
   always_comb begin
      o_hit   = 1'b1;
      o_rdata = 8'h00;
      unique case (i_addr)
         cal_pkg::ADDR_WEEKDAY: o_rdata = {5'h00, weekday_r};
         cal_pkg::ADDR_MONTH:   o_rdata = {3'h0, month_r};
         cal_pkg::ADDR_YEAR:    o_rdata = year_r;
         cal_pkg::ADDR_SEC_ALM: o_rdata = sec_alm_r;
         cal_pkg::ADDR_MIN_ALM: o_rdata = min_alm_r;
         default:               o_hit   = 1'b0;
      endcase
   end

   assign o_weekday      = weekday_r;
   assign o_month        = month_r;
   assign o_year         = year_r;
   assign o_sec_alm_en_n = sec_alm_r[cal_pkg::ALM_EN_BIT];
   assign o_sec_alm_val  = sec_alm_r[cal_pkg::ALM_VAL_W-1:0];
   assign o_min_alm_en_n = min_alm_r[cal_pkg::ALM_EN_BIT];
   assign o_min_alm_val  = min_alm_r[cal_pkg::ALM_VAL_W-1:0];

   // checks
   wday_reset_a: assert property (@(posedge i_clk) $fell(i_rst) |-> weekday_r == 3'h6)
      else $error("weekday not 6 after reset");
   wday_range_a: assert property (@(posedge i_clk) disable iff (i_rst)
      weekday_r == 3'h6 && i_ce && i_day_roll && !wr_ok |=> weekday_r == 3'h0)
      else $error("weekday did not wrap");
   month_reset_a: assert property (@(posedge i_clk) $fell(i_rst) |-> month_r == 5'h01)
      else $error("month not 01 after reset");
   year_reset_a: assert property (@(posedge i_clk) $fell(i_rst) |-> year_r == 8'h00)
      else $error("year not 00 after reset");
   feb_leap_a: assert property (@(posedge i_clk) disable iff (i_rst)
      month_r == 5'h02 && year_r == 8'h24 |-> o_last_day == 6'h29)
      else $error("leap february wrong");
   feb_plain_a: assert property (@(posedge i_clk) disable iff (i_rst)
      month_r == 5'h02 && year_r == 8'h23 |-> o_last_day == 6'h28)
      else $error("plain february wrong");
   year_wrap_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_ce && month_end && month_r == 5'h12 && year_r == 8'h99
      && !wr_ok |=> year_r == 8'h00 && month_r == 5'h01)
      else $error("year did not wrap");
   sec_en_rst_a: assert property (@(posedge i_clk) $fell(i_rst)
      |-> o_sec_alm_en_n && o_sec_alm_val == 7'h00)
      else $error("seconds alarm reset wrong");
   min_en_rst_a: assert property (@(posedge i_clk) $fell(i_rst)
      |-> o_min_alm_en_n && o_min_alm_val == 7'h00)
      else $error("minutes alarm reset wrong");
   sec_val_wr_a: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_ok && i_addr == 8'h0b |=> o_sec_alm_val == $past(i_wdata[6:0]))
      else $error("seconds alarm value not stored");
   min_val_wr_a: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_ok && i_addr == 8'h0c |=> o_min_alm_val == $past(i_wdata[6:0])
      && o_min_alm_en_n == $past(i_wdata[7]))
      else $error("minutes alarm not stored");
   sec_en_wr_a: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_ok && i_addr == 8'h0b |=> o_sec_alm_en_n == $past(i_wdata[7]))
      else $error("seconds alarm enable not stored");
   wday_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
      weekday_r < 3'h6 && i_ce && i_day_roll && !wr_ok
      |=> weekday_r == 3'($past(weekday_r) + 3'h1))
      else $error("weekday did not step");
   feb_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_ce && month_end && month_r == 5'h02 && !wr_ok |=> month_r == 5'h03)
      else $error("month did not leave february");
   // a stalled enable must hold every register, writes and rollovers alike
   ce_freeze_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_ce |=> $stable(weekday_r) && $stable(month_r) && $stable(year_r)
      && $stable(sec_alm_r) && $stable(min_alm_r))
      else $error("state moved while clock enable low");
   hit_decode_a: assert property (@(posedge i_clk)
      o_hit == (i_addr >= 8'h08 && i_addr <= 8'h0c))
      else $error("register hit decode wrong");
endmodule // cal_regs

// *** verif/tb.sv ***
// self-checking bench for the calendar and alarm register block
`timescale 1ns/10ps
module tb;
   localparam logic [7:0] A_WD = cal_pkg::ADDR_WEEKDAY;
   localparam logic [7:0] A_MO = cal_pkg::ADDR_MONTH;
   localparam logic [7:0] A_YR = cal_pkg::ADDR_YEAR;
   localparam logic [7:0] A_SA = cal_pkg::ADDR_SEC_ALM;
   localparam logic [7:0] A_MA = cal_pkg::ADDR_MIN_ALM;
   logic       i_clk      = 1'b0;
   logic       i_rst      = 1'b1;
   logic       i_ce       = 1'b1;
   logic [7:0] i_addr     = 8'h00;
   logic       i_wr       = 1'b0;
   logic [7:0] i_wdata    = 8'h00;
   logic       i_day_roll = 1'b0;
   logic [5:0] i_date     = 6'h01;
   logic [7:0] o_rdata;
   logic       o_hit;
   logic [5:0] o_last_day;
   logic [2:0] o_weekday;
   logic [4:0] o_month;
   logic [7:0] o_year;
   logic       o_sec_alm_en_n;
   logic       o_min_alm_en_n;
   logic [6:0] o_sec_alm_val;
   logic [6:0] o_min_alm_val;
   logic [7:0] yrs [7] = '{8'h00, 8'h10, 8'h12, 8'h23, 8'h24, 8'h96, 8'h99};
   int         mismatches = 0;
   int         num_checks = 0;
   always #25 i_clk = ~i_clk;
   cal_regs uut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wr(i_wr),
      .i_wdata(i_wdata), .o_rdata(o_rdata), .o_hit(o_hit), .i_day_roll(i_day_roll),
      .i_date(i_date), .o_last_day(o_last_day), .o_weekday(o_weekday), .o_month(o_month),
      .o_year(o_year), .o_sec_alm_en_n(o_sec_alm_en_n), .o_sec_alm_val(o_sec_alm_val),
      .o_min_alm_en_n(o_min_alm_en_n), .o_min_alm_val(o_min_alm_val));
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      i_addr = a;
      i_wdata = d;
      i_wr = 1'b1;
      @(negedge i_clk);
      i_wr = 1'b0;
   endtask
   // read data is combinational, so it is sampled 1 ns after the address settles
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge i_clk);
      i_addr = a;
      #1;
      chk("rdata", exp, o_rdata);
      chk("hit", {7'h0, (a >= A_WD) && (a <= A_MA)}, {7'h0, o_hit});
   endtask
   task automatic roll(input logic [5:0] d);
      @(negedge i_clk);
      i_date = d;
      i_day_roll = 1'b1;
      @(negedge i_clk);
      i_day_roll = 1'b0;
   endtask
   // bcd year counts as leap when its decimal value divides by four
   function automatic logic [5:0] last_day(input logic [7:0] m, input logic [7:0] y);
      if (m == 8'h02)
         return ((y[7:4] * 10 + y[3:0]) % 4 == 0) ? 6'h29 : 6'h28;
      if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
         return 6'h30;
      return 6'h31;
   endfunction
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      mismatches++;
      wrap_up();
   end
   initial begin
      logic [7:0] m;
      repeat (3) @(negedge i_clk);
      i_rst = 1'b0;
      rd(A_WD, 8'h06);
      rd(A_MO, 8'h01);
      rd(A_YR, 8'h00);
      rd(A_SA, 8'h80);
      rd(A_MA, 8'h80);
      rd(8'h0d, 8'h00);
      wr(A_SA, 8'h15);
      rd(A_SA, 8'h15);
      chk("sec_alm", 8'h15, {o_sec_alm_en_n, o_sec_alm_val});
      wr(A_MA, 8'hd9);
      rd(A_MA, 8'hd9);
      chk("min_alm", 8'hd9, {o_min_alm_en_n, o_min_alm_val});
      wr(A_WD, 8'hfd);
      rd(A_WD, 8'h05);
      wr(A_MO, 8'he9);
      rd(A_MO, 8'h09);
      for (int y = 0; y < 7; y++) begin
         wr(A_YR, yrs[y]);
         for (int k = 1; k <= 12; k++) begin
            m = (k < 10) ? 8'(k) : 8'(k + 6);
            wr(A_MO, m);
            chk("last_day", {2'b0, last_day(m, yrs[y])}, {2'b0, o_last_day});
         end
      end
      wr(A_WD, 8'h06);
      wr(A_MO, 8'h12);
      wr(A_YR, 8'h99);
      roll(6'h31);
      rd(A_WD, 8'h00);
      rd(A_MO, 8'h01);
      rd(A_YR, 8'h00);
      roll(6'h15);
      rd(A_WD, 8'h01);
      rd(A_MO, 8'h01);
      wr(A_YR, 8'h24);
      wr(A_MO, 8'h02);
      roll(6'h28);
      rd(A_MO, 8'h02);
      roll(6'h29);
      rd(A_MO, 8'h03);
      wr(A_YR, 8'h23);
      wr(A_MO, 8'h02);
      roll(6'h28);
      rd(A_MO, 8'h03);
      wr(A_MO, 8'h04);
      roll(6'h30);
      rd(A_MO, 8'h05);
      wr(A_MO, 8'h12);
      wr(A_YR, 8'h09);
      wr(A_WD, 8'h02);
      // a write to the month in the rollover cycle wins, the year still rolls
      @(negedge i_clk);
      i_addr = A_MO;
      i_wdata = 8'h05;
      i_wr = 1'b1;
      i_date = 6'h31;
      i_day_roll = 1'b1;
      @(negedge i_clk);
      i_wr = 1'b0;
      i_day_roll = 1'b0;
      rd(A_MO, 8'h05);
      rd(A_YR, 8'h10);
      rd(A_WD, 8'h03);
      i_ce = 1'b0;
      wr(A_WD, 8'h01);
      roll(6'h01);
      rd(A_WD, 8'h03);
      i_ce = 1'b1;
      chk("weekday", 8'h03, {5'h00, o_weekday});
      chk("month", 8'h05, {3'h0, o_month});
      chk("year", 8'h10, o_year);
      // second reset in mid-run must restore every default
      @(negedge i_clk);
      i_rst = 1'b1;
      @(negedge i_clk);
      i_rst = 1'b0;
      chk("weekday", 8'h06, {5'h00, o_weekday});
      chk("month", 8'h01, {3'h0, o_month});
      chk("year", 8'h00, o_year);
      chk("sec_alm", 8'h80, {o_sec_alm_en_n, o_sec_alm_val});
      chk("min_alm", 8'h80, {o_min_alm_en_n, o_min_alm_val});
      wrap_up();
   end
endmodule // tb
